// >>> verilog/xpd_pkg.sv
// Constants, encodings and timing for the nibble bus host controller.
// Assumes a single 10 MHz core clock; all pin timing is counted in its cycles.
// Function
// R1: Expander offers four 4-bit bidirectional ports reached over one shared nibble bus.
// R2: Command, port select and data all travel only on the four nibble bus lines.
// R3: Command and port select stand on the bus at the strobe falling edge.
// R4: Write data stands valid on the bus at the strobe rising edge.
// R5: With unit select high the expander ignores the strobe entirely.
// R6: Each port is input, tri-stated in read mode, or a latched output.
// R7: A read tri-states the selected port; otherwise it drives its latch.
// R8: Writes replace, AND or OR the new nibble into the port latch.
// R9: Strobe stays low at least 400 ns in every transfer.
// R10: Command upper bits are the operation, lower bits the port number.
// R11: A read floats the port; the strobe rise ends it and frees the bus.
// R12: First read of a port after a write is discarded by the host.
// R13: After power-on all ports float until the first strobe falling edge.
// R14: Expander drives the bus only from read decode to strobe rise.
package xpd_pkg;

  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;

  // Pin timing in ns
  localparam int SEL_SETUP_NS = 50;
  localparam int SEL_HOLD_NS = 50;
  localparam int CODE_SETUP_NS = 100;
  localparam int CODE_HOLD_NS = 60;
  localparam int DATA_SETUP_NS = 140;
  localparam int DATA_HOLD_NS = 20;
  localparam int STROBE_LOW_NS = 400;
  localparam int READ_ACCESS_NS = 500;
  localparam int READ_FLOAT_NS = 150;

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // Least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    return imax(1, (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  localparam int SETUP_CYC = imax(cyc_up(SEL_SETUP_NS), cyc_up(CODE_SETUP_NS));
  localparam int HOLD_CYC = cyc_up(CODE_HOLD_NS);
  localparam int STROBE_LOW_CYC = cyc_up(STROBE_LOW_NS);
  // Low phase covers the pulse minimum, read access and write data setup
  localparam int LOW_TOTAL_CYC = imax(imax(STROBE_LOW_CYC, cyc_up(READ_ACCESS_NS)),
                                      HOLD_CYC + cyc_up(DATA_SETUP_NS));
  localparam int LOW_CYC = LOW_TOTAL_CYC - HOLD_CYC;
  localparam int END_CYC = imax(imax(cyc_up(DATA_HOLD_NS), cyc_up(READ_FLOAT_NS)),
                                cyc_up(SEL_HOLD_NS));

  localparam int TMR_W = 3;
  typedef logic [TMR_W-1:0] tmr_t;
  // Timer loads hold the phase length minus one
  localparam tmr_t SETUP_LD = tmr_t'(SETUP_CYC - 1);
  localparam tmr_t HOLD_LD = tmr_t'(HOLD_CYC - 1);
  localparam tmr_t LOW_LD = tmr_t'(LOW_CYC - 1);
  localparam tmr_t END_LD = tmr_t'(END_CYC - 1);

  // Command nibble: operation in the upper pair, port in the lower pair
  localparam int CMD_OP_MSB = 3;
  localparam int CMD_OP_LSB = 2;
  localparam int CMD_PORT_MSB = 1;
  localparam int CMD_PORT_LSB = 0;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_DIRECT = 2'h1;
  localparam logic [1:0] OP_OR = 2'h2;
  localparam logic [1:0] OP_AND = 2'h3;

  localparam int NUM_PORTS = 4;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_MAX = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_HOLD = 3'h3,
    ST_LOW = 3'h2,
    ST_END = 3'h6
  } state_e;

endpackage

// >>> verilog/timer_if.sv
// Load and expiry handshake between the controller and its phase timer.
// Assumes both ends run on core_clk.
`timescale 1ns/1ns
`default_nettype none
interface timer_if;
  import xpd_pkg::*;
  logic load;
  tmr_t count;
  logic expired;
  modport ctrl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface
`default_nettype wire

// >>> verilog/cycle_timer.sv
// Down counter that marks the end of a bus phase.
// Assumes load values are the phase length minus one.
`timescale 1ns/1ns
`default_nettype none
module cycle_timer
  import xpd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Controller side
  timer_if.tmr t
);

  typedef struct packed {
    tmr_t cnt;
  } tmr_s;

  tmr_s q;
  tmr_s d;

  always_comb begin
    d = q;
    if (t.load) begin
      d.cnt = t.count;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - tmr_t'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Expiry looks at the count only; the controller decides its load from it,
  // so folding the load back in here would close a combinational loop
  assign t.expired = (q.cnt == '0);

endmodule
`default_nettype wire

// >>> verilog/nibble_bus_host.sv
// Host controller that drives a four-port nibble bus I/O expander.
// Assumes the expander pins are wired directly; bus input is synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module nibble_bus_host
  import xpd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // User request
  input wire logic req,
  input wire logic [1:0] req_op,
  input wire logic [1:0] req_port,
  input wire logic [3:0] req_data,
  // User answer
  output logic busy,
  output logic done,
  output logic [3:0] rd_data,
  // Expander pins
  output logic transfer_strobe_n,
  output logic unit_select_n,
  output logic [3:0] host_nibble_bus_o,
  output logic host_nibble_bus_oe_n,
  input wire logic [3:0] host_nibble_bus_i
);

  typedef struct packed {
    state_e st;
    logic strobe_n;
    logic sel_n;
    logic [3:0] bus_o;
    logic bus_oe_n;
    logic busy;
    logic done;
    logic [3:0] rdata;
    logic [1:0] op;
    logic [1:0] port;
    logic [3:0] wdata;
    logic [NUM_PORTS-1:0] written;
    logic dummy;
    logic [3:0] low_cnt;
  } ctl_s;

  localparam ctl_s CTL_RESET = '{
    st: ST_IDLE, strobe_n: 1'b1, sel_n: 1'b1, bus_o: NIBBLE_ZERO, bus_oe_n: 1'b1,
    busy: 1'b0, done: 1'b0, rdata: NIBBLE_ZERO, op: OP_READ, port: 2'h0,
    wdata: NIBBLE_ZERO, written: '0, dummy: 1'b0, low_cnt: NIBBLE_ZERO};

  ctl_s q;
  ctl_s d;
  timer_if tif ();

  cycle_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .t(tif.tmr)
  );

  always_comb begin
    d = q;
    d.done = 1'b0;
    tif.load = 1'b0;
    tif.count = '0;
    // Strobe low width kept for checking; saturates
    if (q.strobe_n) begin
      d.low_cnt = NIBBLE_ZERO;
    end else if (q.low_cnt != CNT_MAX) begin
      d.low_cnt = q.low_cnt + CNT_ONE;
    end
    case (q.st)
      ST_IDLE: begin
        if (req) begin
          d.op = req_op;
          d.port = req_port;
          d.wdata = req_data;
          d.busy = 1'b1;
          // A read of a port whose last transfer was a write gets a throwaway pass first
          d.dummy = (req_op == OP_READ) && q.written[req_port]; // [R12]
          d.sel_n = 1'b0;
          d.bus_o = {req_op, req_port}; // [R2] [R10]
          d.bus_oe_n = 1'b0;
          d.st = ST_SETUP;
          tif.load = 1'b1;
          tif.count = SETUP_LD;
        end
      end
      ST_SETUP: begin
        if (tif.expired) begin
          d.strobe_n = 1'b0; // [R3]
          d.st = ST_HOLD;
          tif.load = 1'b1;
          tif.count = HOLD_LD;
        end
      end
      ST_HOLD: begin
        if (tif.expired) begin
          if (q.op == OP_READ) begin
            d.bus_oe_n = 1'b1; // [R14] [R11]
          end else begin
            d.bus_o = q.wdata; // [R4] [R8]
          end
          d.st = ST_LOW;
          tif.load = 1'b1;
          tif.count = LOW_LD;
        end
      end
      ST_LOW: begin
        if (tif.expired) begin
          d.strobe_n = 1'b1; // [R9] [R4]
          if (q.op == OP_READ && !q.dummy) begin
            d.rdata = host_nibble_bus_i; // [R11]
          end
          // Any read leaves the port floating; a write leaves it driving
          d.written[q.port] = (q.op != OP_READ); // [R1] [R6] [R7]
          d.st = ST_END;
          tif.load = 1'b1;
          tif.count = END_LD;
        end
      end
      ST_END: begin
        if (tif.expired) begin
          if (q.dummy) begin
            d.dummy = 1'b0; // [R12]
            d.bus_o = {q.op, q.port};
            d.bus_oe_n = 1'b0;
            d.st = ST_SETUP;
            tif.load = 1'b1;
            tif.count = SETUP_LD;
          end else begin
            // Select drops only after data hold and expander float time
            d.sel_n = 1'b1; // [R5]
            d.bus_oe_n = 1'b1;
            d.busy = 1'b0;
            d.done = 1'b1;
            d.st = ST_IDLE;
          end
        end
      end
      default: begin
        d = CTL_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  // Expander leaves its power-on state at the first fall; nothing to do here [R13]
  assign busy = q.busy;
  assign done = q.done;
  assign rd_data = q.rdata;
  assign transfer_strobe_n = q.strobe_n;
  assign unit_select_n = q.sel_n;
  assign host_nibble_bus_o = q.bus_o;
  assign host_nibble_bus_oe_n = q.bus_oe_n;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_strobe_low_min: assert property ( // [R9]
    $rose(q.strobe_n) |-> q.low_cnt >= 4'(STROBE_LOW_CYC))
    else $error("strobe low pulse too short");

  a_strobe_low_max: assert property ( // [R9]
    $fell(q.strobe_n) |-> ##[1:8] $rose(q.strobe_n))
    else $error("strobe never returned high");

  a_cmd_at_fall: assert property ( // [R3] [R10]
    $fell(q.strobe_n) |-> !q.bus_oe_n && q.bus_o == {q.op, q.port} && !q.sel_n)
    else $error("command nibble not on bus at strobe fall");

  a_cmd_setup: assert property ( // [R3]
    $fell(q.strobe_n) |-> !$past(q.bus_oe_n) && $past(q.bus_o) == q.bus_o)
    else $error("command nibble changed before strobe fall");

  a_req_to_fall: assert property ( // [R3]
    q.st == ST_IDLE && req |-> ##2 $fell(q.strobe_n))
    else $error("strobe fall not two cycles after request");

  a_write_data: assert property ( // [R4]
    $rose(q.strobe_n) && q.op != OP_READ
      |-> (!q.bus_oe_n && q.bus_o == q.wdata) [*2])
    else $error("write data not held across strobe rise");

  a_read_float: assert property ( // [R14]
    q.st == ST_LOW && q.op == OP_READ |-> q.bus_oe_n)
    else $error("host drives bus during read");

  a_float_gap: assert property ( // [R11]
    $rose(q.strobe_n) && q.op == OP_READ |-> q.bus_oe_n [*2])
    else $error("host drives bus too soon after read");

  a_select_frame: assert property ( // [R5]
    !q.strobe_n |-> !q.sel_n && $past(!q.sel_n))
    else $error("strobe low without unit select");

  a_stale_retry: assert property ( // [R12]
    q.done && q.op == OP_READ |-> !q.written[q.port] && !q.dummy)
    else $error("read reported without discarding stale pass");

  // A request in the done cycle is taken, so busy may rise right after done
  a_done_pulse: assert property (
    q.done |=> !q.done && q.busy == $past(req))
    else $error("done not a single pulse");

endmodule
`default_nettype wire

// >>> bench/expander_model.sv
// Behavioural four-port nibble bus expander facing the host controller.
// Assumes the bench resolves the shared bus and feeds the wire back on bus_in.
`timescale 1ns/1ns
`default_nettype none
module expander_model (
  // Host pins
  input wire logic strobe_n,
  input wire logic sel_n,
  input wire logic [3:0] bus_in,
  output logic [3:0] bus_out,
  output logic bus_drive,
  // Expansion ports, four nibbles
  input wire logic [15:0] ext_in,
  output logic [15:0] port_out,
  output logic [3:0] port_float
);
  logic [1:0] op;
  logic [1:0] pt;
  logic [3:0] settled;
  // Power-on: ports float, bus is input
  initial begin
    port_float = 4'hf;
    port_out = 16'h0000;
    bus_drive = 1'b0;
    bus_out = 4'h0;
    settled = 4'hf;
  end
  // Command taken on the fall; a deselected unit sees nothing
  always @(negedge strobe_n) if (!sel_n) begin
    op = bus_in[3:2];
    pt = bus_in[1:0];
    if (op == 2'h0) begin
      port_float[pt] = 1'b1;
      // Freshly released port has not settled, so the first answer is junk
      bus_out <= #150 settled[pt] ? ext_in[pt*4+:4] : ~ext_in[pt*4+:4];
      // Drive only after decode, once the host has let go
      bus_drive <= #150 1'b1;
      settled[pt] = 1'b1;
    end
  end
  // Data nibble taken on the rise
  always @(posedge strobe_n) if (!sel_n) begin
    bus_drive = 1'b0;
    case (op)
      2'h1: port_out[pt*4+:4] = bus_in;
      2'h2: port_out[pt*4+:4] = port_out[pt*4+:4] | bus_in;
      2'h3: port_out[pt*4+:4] = port_out[pt*4+:4] & bus_in;
      default: ;
    endcase
    if (op != 2'h0) begin
      port_float[pt] = 1'b0;
      settled[pt] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/nibble_bus_io_expander_tb_top.sv
// Self-checking bench: host controller against the expander model.
// Assumes xpd_pkg and expander_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module nibble_bus_io_expander_tb_top;
  import xpd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [1:0] req_port = 2'h0;
  logic [3:0] req_data = 4'h0;
  logic busy, done, transfer_strobe_n, unit_select_n, host_nibble_bus_oe_n, m_drive;
  logic [3:0] rd_data, host_nibble_bus_o, host_nibble_bus_i, m_out;
  logic [3:0] float_q = 4'h0;
  logic [15:0] ext_q = 16'h0000;
  logic [15:0] port_out;
  logic [3:0] port_float;
  logic [7:0] lfsr_q = 8'h53;
  logic [3:0] exp_port [4];
  bit written [4];
  int fails = 0;
  int total_checks = 0;
  int low_n = 0;

  always #50 core_clk = ~core_clk;

  nibble_bus_host dut (
    .core_clk(core_clk),
    .rst(rst),
    .req(req),
    .req_op(req_op),
    .req_port(req_port),
    .req_data(req_data),
    .busy(busy),
    .done(done),
    .rd_data(rd_data),
    .transfer_strobe_n(transfer_strobe_n),
    .unit_select_n(unit_select_n),
    .host_nibble_bus_o(host_nibble_bus_o),
    .host_nibble_bus_oe_n(host_nibble_bus_oe_n),
    .host_nibble_bus_i(host_nibble_bus_i)
  );
  expander_model xp (.strobe_n(transfer_strobe_n), .sel_n(unit_select_n),
    .bus_in(host_nibble_bus_i), .bus_out(m_out), .bus_drive(m_drive), .ext_in(ext_q),
    .port_out, .port_float);

  // Released wire has no pull, so it wanders instead of keeping its level
  always @(posedge core_clk) float_q <= float_q + 4'h7;
  always_comb begin
    if (!host_nibble_bus_oe_n) host_nibble_bus_i = host_nibble_bus_o;
    else if (m_drive) host_nibble_bus_i = m_out;
    else host_nibble_bus_i = float_q;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (!rst) begin
      chk("contention", {15'h0, !host_nibble_bus_oe_n && m_drive}, 16'h0);
      chk("strobe unselected", {15'h0, !transfer_strobe_n && unit_select_n}, 16'h0);
      if (!transfer_strobe_n) low_n++;
      else if (low_n > 0) begin
        chk("strobe short", {15'h0, low_n < STROBE_LOW_CYC}, 16'h0);
        low_n = 0;
      end
    end
  end

  task automatic xfer(input logic [1:0] op, input logic [1:0] pt, input logic [3:0] d);
    int n;
    int lat;
    // A throwaway pass repeats the whole eight-cycle frame before the kept one
    lat = (op == OP_READ && written[pt]) ? 18 : 10;
    req <= 1'b1;
    req_op <= op;
    req_port <= pt;
    req_data <= d;
    @(posedge core_clk);
    req <= 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk("latency", n[15:0], lat[15:0]);
    if (op == OP_READ) begin
      chk("read", {12'h0, rd_data}, {12'h0, ext_q[pt*4+:4]});
      chk("port float", {15'h0, port_float[pt]}, 16'h1);
      written[pt] = 1'b0;
    end else begin
      case (op)
        OP_DIRECT: exp_port[pt] = d;
        OP_OR: exp_port[pt] = exp_port[pt] | d;
        default: exp_port[pt] = exp_port[pt] & d;
      endcase
      chk("latch", {12'h0, port_out[pt*4+:4]}, {12'h0, exp_port[pt]});
      chk("port drive", {15'h0, port_float[pt]}, 16'h0);
      written[pt] = 1'b1;
    end
  endtask

  initial begin
    logic [1:0] op;
    logic [1:0] pt;
    foreach (exp_port[k]) exp_port[k] = 4'h0;
    repeat (5) @(posedge core_clk);
    chk("reset pins", {7'h0, transfer_strobe_n, unit_select_n, host_nibble_bus_oe_n, busy,
      done, rd_data}, 16'h01c0);
    chk("power-on ports", {12'h0, port_float}, 16'h000f);
    rst <= 1'b0;
    @(posedge core_clk);
    // Fixed part: every op on every port, the direct write followed by a read
    for (int i = 0; i < 48; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      op = (i < 16) ? (i[1:0] ^ 2'h1) : lfsr_q[1:0];
      pt = (i < 16) ? i[3:2] : lfsr_q[3:2];
      ext_q[pt*4+:4] <= lfsr_q[7:4] ^ 4'h9;
      xfer(op, pt, lfsr_q[7:4]);
    end
    close_out();
  end

  // 48 transfers of at most 18 cycles, with wide margin
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
